// file: logic/fsb_map.svh
// Purpose: offsets, fields and timing counts of the frame_store controller pair
// Assumes: 50 MHz aclk, 16-bit painter_internal_bus words
// Notes:   counts derive from times; least times round up
`ifndef FSB_MAP_SVH
`define FSB_MAP_SVH

`define FSB_CLK_NS        20
`define FSB_ACC_NS        120
`define FSB_ACC_CYC       ((`FSB_ACC_NS + `FSB_CLK_NS - 1) / `FSB_CLK_NS)
`define FSB_REF_NS        120
`define FSB_REF_CYC       ((`FSB_REF_NS + `FSB_CLK_NS - 1) / `FSB_CLK_NS)
`define FSB_REF_INT_NS    15600
`define FSB_REF_INT_CYC   (`FSB_REF_INT_NS / `FSB_CLK_NS)
`define FSB_RMW_WAIT      4

// high pointer word: upper address bits and mode
`define FSB_HI_ADDR_W     4
`define FSB_HI_RMW_BIT    15

// host register offsets
`define FSB_OFF_CMD       32'h0000_0000
`define FSB_OFF_STAT      32'h0000_0004
`define FSB_OFF_RDAT      32'h0000_0008

// command register fields
`define FSB_CMD_LDHI      16
`define FSB_CMD_LDLO      17
`define FSB_CMD_START     18
`define FSB_CMD_WR        19
`define FSB_CMD_RD        20

// status register fields
`define FSB_ST_READY      0
`define FSB_ST_BUSY       1
`define FSB_ST_ERR        2
`define FSB_ST_RMW        3

`define FSB_RESP_OKAY     2'h0
`define FSB_RESP_SLVERR   2'h2

`endif

// file: logic/fsb_pkg.sv
// Purpose: types shared by both ends of the frame_store link
// Assumes: widths written as literals; fsb_map.svh is not included
// Notes:   one packed state struct per end
package fsb_pkg;

   typedef enum logic [2:0] {DS_IDLE, DS_REF, DS_READ, DS_WRITE, DS_OPEN} fsb_dev_e;

   typedef struct packed {
      fsb_dev_e    st;
      logic        ready;
      logic        rmw;
      logic [3:0]  hi;
      logic [15:0] lo;
      logic [15:0] rdat;
      logic [15:0] wdat;
      logic [7:0]  cnt;
      logic        ref_pend;
   } fsb_dev_s;

   typedef struct packed {
      logic        aw_have;
      logic [31:0] awaddr;
      logic        w_have;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        pend;
      logic [20:0] cmd;
      logic        settle;
      logic        ld_hi;
      logic        ld_lo;
      logic        start_rd;
      logic        wr_ld;
      logic [15:0] bus;
      logic        rmw;
      logic [2:0]  wait_cnt;
      logic        lo_set;
      logic        start_seen;
      logic        err;
      logic [15:0] rdcap;
   } fsb_host_s;

endpackage

// file: logic/fsb_link_if.sv
// Purpose: painter_internal_bus link between microcode side and frame_store controller
// Assumes: both ends on aclk
// Notes:   strobes are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface fsb_link_if;
   logic        ld_hi;
   logic        ld_lo;
   logic        start_rd;
   logic        wr_ld;
   logic [15:0] bus_data;
   logic        ready;
   logic [15:0] rd_data;

   modport dev  (input ld_hi, ld_lo, start_rd, wr_ld, bus_data, output ready, rd_data);
   modport host (output ld_hi, ld_lo, start_rd, wr_ld, bus_data, input ready, rd_data);
endinterface
`default_nettype wire

// file: logic/fsb_tick.sv
// Purpose: periodic one-cycle enable for refresh
// Assumes: aclk domain
// Notes:   period in cycles is a parameter
`timescale 1ns/1ps
`default_nettype none
module fsb_tick #(
   parameter int PERIOD = 780
) (
   // clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // enable out
   output logic      tick
);
   logic [15:0] cnt_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= 16'h0000;
         tick  <= 1'b0;
      end else begin
         tick <= (cnt_q == 16'(PERIOD - 1));
         if (cnt_q == 16'(PERIOD - 1)) begin
            cnt_q <= 16'h0000;
         end else begin
            cnt_q <= cnt_q + 16'h0001;
         end
      end
   end
endmodule
`default_nettype wire

// file: logic/fsb_frame_store_ctrl.sv
// Purpose: frame_store DRAM controller, normal and read-modify-write modes
// Assumes: microcode end keeps its own ordering duties; one clock
// Notes:   memory is an internal array; refresh stretches accesses
// Notes on behaviour
// - rmw: low pointer plus start opens cycle
// - rmw: data load writes, increments, reopens cycle
// - microcode: start-read before first rmw write
// - rmw: lone start closes unwritten, increments, reopens
// - high pointer mode write leaves rmw, no write
// - microcode waits four cycles before rmw start
// - microcode never reloads low pointer in rmw
// - operations accepted only while ready is set
// - start-read or data load clears ready
// - ready set on read done; write only normal
// - own refresh stretches access; microcode polls ready
// - start-read with data load is ignored
// - mode change accepted while ready, open included, not with start-read
`timescale 1ns/1ps
`default_nettype none
`include "fsb_map.svh"
module fsb_frame_store_ctrl #(
   parameter int ADDR_W  = 20,
   parameter int REF_INT = `FSB_REF_INT_CYC
) (
   // clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // link to microcode end
   fsb_link_if.dev   lnk,
   // status
   output logic      rmw_mode,
   output logic      refreshing
);
   localparam logic [7:0] ACC = 8'(`FSB_ACC_CYC);
   localparam logic [7:0] REF = 8'(`FSB_REF_CYC);

   fsb_pkg::fsb_dev_s q, d;
   logic [15:0]       mem [0:(1 << ADDR_W) - 1];
   logic              tick;
   logic              mem_we;
   logic [19:0]       ptr;
   logic [19:0]       ptr_inc;
   logic              go_start;
   logic              cmd;
   logic [7:0]        acc_cnt;

   fsb_tick #(.PERIOD(REF_INT)) u_ref (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tick    (tick)
   );

   assign ptr      = {q.hi, q.lo};
   assign ptr_inc  = ptr + 20'h00001;
   assign go_start = lnk.start_rd & ~lnk.wr_ld;
   assign cmd      = q.ready & (lnk.wr_ld | go_start | lnk.ld_lo);
   // refresh due or running folds into the access time
   assign acc_cnt  = (q.st == fsb_pkg::DS_REF) ? q.cnt + ACC :
                     (q.ref_pend ? ACC + REF : ACC);

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      d      = q;
      mem_we = 1'b0;
      if (tick) begin
         d.ref_pend = 1'b1;
      end
      unique case (q.st)
         fsb_pkg::DS_IDLE, fsb_pkg::DS_REF, fsb_pkg::DS_OPEN: begin
            if (q.st == fsb_pkg::DS_REF) begin
               d.cnt = q.cnt - 8'h01;
               if (q.cnt == 8'h01) begin
                  d.st = fsb_pkg::DS_IDLE;
               end
            end
            // a bare low pointer load must not restart or swallow a refresh
            if (cmd && (lnk.wr_ld || go_start)) begin
               d.cnt = acc_cnt;
               if (q.st != fsb_pkg::DS_OPEN) begin
                  d.ref_pend = tick;
               end
            end
            if (cmd && lnk.wr_ld) begin
               // rmw write closes the open cycle by writing it
               d.wdat  = lnk.bus_data;
               d.ready = 1'b0;
               d.st    = fsb_pkg::DS_WRITE;
            end else if (cmd && go_start) begin
               d.ready = 1'b0;
               d.st    = fsb_pkg::DS_READ;
               if (lnk.ld_lo) begin
                  d.lo = lnk.bus_data;
               end else begin
                  // next word: open rmw dropped with no write, or a sequential read in normal mode
                  {d.hi, d.lo} = ptr_inc;
               end
            end else if (cmd && lnk.ld_lo) begin
               d.lo = lnk.bus_data;
            end else if (q.st == fsb_pkg::DS_IDLE && q.ref_pend) begin
               d.st       = fsb_pkg::DS_REF;
               d.cnt      = REF;
               d.ref_pend = tick;
            end
            if (lnk.ld_hi && !lnk.start_rd && (q.ready || q.st == fsb_pkg::DS_OPEN)) begin
               d.hi  = lnk.bus_data[`FSB_HI_ADDR_W-1:0];
               d.rmw = lnk.bus_data[`FSB_HI_RMW_BIT];
               // leaving rmw ends the open cycle unwritten
               if (q.st == fsb_pkg::DS_OPEN && !lnk.bus_data[`FSB_HI_RMW_BIT]) begin
                  d.st = fsb_pkg::DS_IDLE;
               end
            end
         end
         fsb_pkg::DS_READ: begin
            d.cnt = q.cnt - 8'h01;
            if (q.cnt == 8'h01) begin
               d.rdat  = mem[ptr[ADDR_W-1:0]];
               d.ready = 1'b1;
               d.st    = q.rmw ? fsb_pkg::DS_OPEN : fsb_pkg::DS_IDLE;
            end
         end
         fsb_pkg::DS_WRITE: begin
            d.cnt = q.cnt - 8'h01;
            if (q.cnt == 8'h01) begin
               mem_we       = 1'b1;
               {d.hi, d.lo} = ptr_inc;
               if (q.rmw) begin
                  // ready stays clear until the new fetch lands
                  d.st  = fsb_pkg::DS_READ;
                  d.cnt = ACC;
               end else begin
                  d.ready = 1'b1;
                  d.st    = fsb_pkg::DS_IDLE;
               end
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q          <= '0;
         q.st       <= fsb_pkg::DS_IDLE;
         q.ready    <= 1'b1;
         rmw_mode   <= 1'b0;
         refreshing <= 1'b0;
      end else begin
         q          <= d;
         rmw_mode   <= d.rmw;
         refreshing <= (d.st == fsb_pkg::DS_REF);
      end
   end

   // memory has no reset; it is the frame store itself
   always_ff @(posedge aclk) begin
      if (mem_we) begin
         mem[ptr[ADDR_W-1:0]] <= q.wdat;
      end
   end

   assign lnk.ready   = q.ready;
   assign lnk.rd_data = q.rdat;
endmodule
`default_nettype wire

// file: logic/fsb_painter_ctrl.sv
// Purpose: microcode-side end: AXI4-Lite command registers driving the link
// Assumes: device end on the same aclk
// Notes:   one command at a time; waits on ready, on a count only after rmw entry
`timescale 1ns/1ps
`default_nettype none
`include "fsb_map.svh"
module fsb_painter_ctrl (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // link to device end
   fsb_link_if.host         lnk
);
   fsb_pkg::fsb_host_s q, d;
   logic               rmw_new;
   logic               refuse;
   logic               hold;

   assign rmw_new = q.cmd[`FSB_HI_RMW_BIT];
   // microcode duties kept here: refuse what would corrupt the device
   assign refuse  = q.rmw && ((q.cmd[`FSB_CMD_LDLO] && q.lo_set)
                   || (q.cmd[`FSB_CMD_WR] && !q.start_seen));
   assign hold    = q.rmw && q.cmd[`FSB_CMD_LDLO] && q.cmd[`FSB_CMD_START]
                   && (q.wait_cnt != 3'h0);

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      d          = q;
      d.ld_hi    = 1'b0;
      d.ld_lo    = 1'b0;
      d.start_rd = 1'b0;
      d.wr_ld    = 1'b0;
      d.settle   = 1'b0;
      if (q.wait_cnt != 3'h0) begin
         d.wait_cnt = q.wait_cnt - 3'h1;
      end
      // write channel: address and data in either order
      if (s_axi_awvalid && q.awready) begin
         d.aw_have = 1'b1;
         d.awaddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && q.wready) begin
         d.w_have = 1'b1;
         d.wdata  = s_axi_wdata;
         d.wstrb  = s_axi_wstrb;
      end
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end
      if (q.aw_have && q.w_have && !q.bvalid) begin
         d.aw_have = 1'b0;
         d.w_have  = 1'b0;
         d.bvalid  = 1'b1;
         d.bresp   = `FSB_RESP_OKAY;
         if (q.awaddr == `FSB_OFF_CMD && !q.pend && q.wstrb == 4'hF) begin
            d.pend = 1'b1;
            d.cmd  = q.wdata[20:0];
         end else if (q.awaddr == `FSB_OFF_STAT) begin
            if (q.wdata[`FSB_ST_ERR] && q.wstrb[0]) begin
               d.err = 1'b0;
            end
         end else begin
            // busy command register, partial write or unmapped
            d.bresp = `FSB_RESP_SLVERR;
         end
      end
      d.awready = !d.aw_have && !d.bvalid;
      d.wready  = !d.w_have && !d.bvalid;
      // read channel
      if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && q.arready) begin
         d.rvalid = 1'b1;
         d.rresp  = `FSB_RESP_OKAY;
         d.rdata  = 32'h0000_0000;
         if (s_axi_araddr == `FSB_OFF_STAT) begin
            d.rdata[`FSB_ST_READY] = lnk.ready;
            d.rdata[`FSB_ST_BUSY]  = q.pend;
            d.rdata[`FSB_ST_ERR]   = q.err;
            d.rdata[`FSB_ST_RMW]   = q.rmw;
         end else if (s_axi_araddr == `FSB_OFF_RDAT) begin
            d.rdata[15:0] = q.rdcap;
         end else if (s_axi_araddr == `FSB_OFF_CMD) begin
            d.rdata[20:0] = q.cmd;
         end else begin
            d.rresp = `FSB_RESP_SLVERR;
         end
      end
      d.arready = !d.rvalid;
      // issue: ready polled, skipping the cycle in which a strobe is on the link
      if (q.pend && lnk.ready && !q.settle && !hold) begin
         d.pend = 1'b0;
         if (refuse) begin
            d.err = 1'b1; // an error raised here beats a same-cycle clear
         end else begin
            d.bus      = q.cmd[15:0];
            d.ld_hi    = q.cmd[`FSB_CMD_LDHI];
            d.ld_lo    = q.cmd[`FSB_CMD_LDLO];
            // start rides along with a data load; the device drops it
            d.start_rd = q.cmd[`FSB_CMD_START];
            d.wr_ld    = q.cmd[`FSB_CMD_WR];
            d.settle   = 1'b1;
            if (q.cmd[`FSB_CMD_RD]) begin
               d.rdcap = lnk.rd_data;
            end
            if (q.cmd[`FSB_CMD_START] && !q.cmd[`FSB_CMD_WR]) begin
               d.start_seen = 1'b1;
            end
            if (q.cmd[`FSB_CMD_LDLO] && q.rmw) begin
               d.lo_set = 1'b1;
            end
            if (q.cmd[`FSB_CMD_LDHI]) begin
               d.rmw = rmw_new;
               if (rmw_new && !q.rmw) begin
                  d.wait_cnt   = 3'(`FSB_RMW_WAIT);
                  d.lo_set     = 1'b0;
                  d.start_seen = 1'b0;
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign s_axi_awready = q.awready;
   assign s_axi_wready  = q.wready;
   assign s_axi_bvalid  = q.bvalid;
   assign s_axi_bresp   = q.bresp;
   assign s_axi_arready = q.arready;
   assign s_axi_rvalid  = q.rvalid;
   assign s_axi_rdata   = q.rdata;
   assign s_axi_rresp   = q.rresp;
   assign lnk.ld_hi     = q.ld_hi;
   assign lnk.ld_lo     = q.ld_lo;
   assign lnk.start_rd  = q.start_rd;
   assign lnk.wr_ld     = q.wr_ld;
   assign lnk.bus_data  = q.bus;
endmodule
`default_nettype wire

// file: verif/fsb_link_asserts.sv
// Purpose: link checks between the two frame_store ends
// Assumes: one aclk, synchronous active-low reset
// Notes:   helper flags follow every ld_hi while ready, also one the device drops with start-read
`timescale 1ns/1ps
`default_nettype none
`include "fsb_map.svh"
module fsb_link_asserts (
   // clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // link strobes and data
   input wire logic        ld_hi,
   input wire logic        ld_lo,
   input wire logic        start_rd,
   input wire logic        wr_ld,
   input wire logic [15:0] bus_data,
   // device answers
   input wire logic        ready,
   input wire logic [15:0] rd_data
);
   logic mode_q;
   logic lo_set_q;
   logic seen_q;
   logic hi_tk;

   // ld_hi only counts when the device is ready
   assign hi_tk = ld_hi && ready;

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_q   <= 1'b0;
         lo_set_q <= 1'b0;
         seen_q   <= 1'b0;
      end else begin
         if (hi_tk) mode_q <= bus_data[`FSB_HI_RMW_BIT];
         if (hi_tk) lo_set_q <= 1'b0;
         else if (mode_q && ld_lo && ready) lo_set_q <= 1'b1;
         if (hi_tk) seen_q <= 1'b0;
         else if (start_rd && !wr_ld && ready) seen_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   strobe_ready_a: assert property ((ld_hi || ld_lo || start_rd || wr_ld) |-> ready)
      else $error("strobe while not ready");
   start_clear_a: assert property (start_rd && ready |=> !ready)
      else $error("start-read left ready set");
   load_clear_a: assert property (wr_ld && ready |=> !ready)
      else $error("data load left ready set");
   idle_keep_a: assert property (ready && !start_rd && !wr_ld |=> ready)
      else $error("ready fell without a command");
   data_hold_a: assert property (ready && $past(ready) |-> $stable(rd_data))
      else $error("read word changed while idle");
   access_min_a: assert property ($fell(ready) |-> !ready[*5])
      else $error("access shorter than an access time");
   access_max_a: assert property ($fell(ready) |-> ##[1:60] ready)
      else $error("ready not restored");
   rmw_write_a: assert property (mode_q && wr_ld && ready |=> !ready[*8])
      else $error("rmw write did not also read");
   entry_gap_a: assert property (hi_tk && bus_data[`FSB_HI_RMW_BIT] && !mode_q
      |=> (!(ld_lo && start_rd))[*4])
      else $error("rmw start too soon after entry");
   lo_once_a: assert property (mode_q && ld_lo && ready |-> !lo_set_q)
      else $error("low pointer reloaded in rmw");
   start_first_a: assert property (mode_q && wr_ld && ready |-> seen_q)
      else $error("rmw write before start-read");
endmodule
`default_nettype wire

// file: verif/test_graphics_buffer_rmw_dram_ctrl.sv
// Purpose: both frame_store ends joined, driven over AXI4-Lite
// Assumes: 50 MHz aclk, command and status registers of the host end
// Notes:   memory is not reset, so reads only hit written words
`timescale 1ns/1ps
`default_nettype none
`include "fsb_map.svh"
module test_graphics_buffer_rmw_dram_ctrl;
   typedef struct packed {
      logic [20:0] cmd;
      logic        chk;
      logic [15:0] exp;
   } fsb_row_s;

   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [31:0] awaddr = '0;
   logic        awvalid = 1'b0;
   logic [31:0] wdata = '0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic [31:0] araddr = '0;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, rmw_mode, refreshing;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   int          errors = 0;
   int          checked = 0;
   int          cycles = 0;
   logic [1:0]  wr_resp = 2'h0;
   // wr+start row: a taken start would shift every later word
   fsb_row_s    rows [10] = '{
      '{21'h010000, 1'b0, 16'h0000}, '{21'h020010, 1'b0, 16'h0000},
      '{21'h081111, 1'b0, 16'h0000}, '{21'h082222, 1'b0, 16'h0000},
      '{21'h0C3333, 1'b0, 16'h0000}, '{21'h084444, 1'b0, 16'h0000},
      '{21'h060010, 1'b1, 16'h1111}, '{21'h040000, 1'b1, 16'h2222},
      '{21'h040000, 1'b1, 16'h3333}, '{21'h040000, 1'b1, 16'h4444}};

   fsb_link_if lnk ();

   fsb_painter_ctrl i_fsb_painter_ctrl (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .lnk(lnk.host));

   // short refresh period so refreshes land inside accesses
   fsb_frame_store_ctrl #(.REF_INT(40)) i_fsb_frame_store_ctrl (
      .aclk(aclk), .aresetn(aresetn), .lnk(lnk.dev),
      .rmw_mode(rmw_mode), .refreshing(refreshing));

   fsb_link_asserts i_chk (
      .aclk(aclk), .aresetn(aresetn), .ld_hi(lnk.ld_hi), .ld_lo(lnk.ld_lo),
      .start_rd(lnk.start_rd), .wr_ld(lnk.wr_ld), .bus_data(lnk.bus_data),
      .ready(lnk.ready), .rd_data(lnk.rd_data));

   ////////////////////////////////////////////////////////////////////////////////
   always #10 aclk = ~aclk;

   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors++;
         give_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      wr_resp = bresp;
      bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   // no fixed latency: poll busy, then the link's own ready
   task automatic idle();
      logic [31:0] d;
      logic [1:0]  r;
      do axi_rd(`FSB_OFF_STAT, d, r); while (d[`FSB_ST_BUSY] !== 1'b0);
      repeat (2) @(posedge aclk);
      while (lnk.ready !== 1'b1) @(posedge aclk);
   endtask

   task automatic op(input logic [20:0] c, input logic k, input logic [15:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      axi_wr(`FSB_OFF_CMD, {11'h000, c});
      idle();
      if (k) begin
         axi_wr(`FSB_OFF_CMD, 32'h0010_0000);
         idle();
         axi_rd(`FSB_OFF_RDAT, d, r);
         chk("read word", {16'h0000, e}, d);
      end
   endtask

   task automatic err_flag();
      logic [31:0] d;
      logic [1:0]  r;
      axi_rd(`FSB_OFF_STAT, d, r);
      chk("error flag", 32'h1, {31'h0, d[`FSB_ST_ERR]});
      axi_wr(`FSB_OFF_STAT, 32'h0000_0004);
      chk("write response", {30'h0, `FSB_RESP_OKAY}, {30'h0, wr_resp});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] d;
      logic [1:0]  r;
      int          n;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(`FSB_OFF_STAT, d, r);
      chk("status after reset", 32'h0000_0001, d);
      chk("read response", {30'h0, `FSB_RESP_OKAY}, {30'h0, r});
      axi_rd(`FSB_OFF_RDAT, d, r);
      chk("read word after reset", 32'h0, d);
      foreach (rows[i]) op(rows[i].cmd, rows[i].chk, rows[i].exp);
      op(21'h018000, 1'b0, 16'h0000);
      chk("mode", 32'h1, {31'h0, rmw_mode});
      op(21'h060010, 1'b1, 16'h1111);
      op(21'h08AAAA, 1'b1, 16'h2222);
      op(21'h040000, 1'b1, 16'h3333);
      op(21'h020020, 1'b0, 16'h0000);
      err_flag();
      op(21'h010000, 1'b0, 16'h0000);
      chk("mode", 32'h0, {31'h0, rmw_mode});
      op(21'h060010, 1'b1, 16'hAAAA);
      op(21'h040000, 1'b1, 16'h2222);
      op(21'h040000, 1'b1, 16'h3333);
      op(21'h018000, 1'b0, 16'h0000);
      op(21'h085555, 1'b0, 16'h0000);
      err_flag();
      op(21'h010000, 1'b0, 16'h0000);
      axi_rd(32'h0000_000C, d, r);
      chk("unmapped response", {30'h0, `FSB_RESP_SLVERR}, {30'h0, r});
      axi_wr(32'h0000_000C, 32'h0000_0000);
      chk("unmapped write response", {30'h0, `FSB_RESP_SLVERR}, {30'h0, wr_resp});
      // refresh period is 40 cycles here, so 100 idle cycles must show one
      n = 0;
      while (refreshing !== 1'b1 && n < 100) begin
         @(posedge aclk);
         n++;
      end
      chk("refresh seen", 32'h1, {31'h0, refreshing});
      give_verdict();
   end
endmodule
`default_nettype wire
